// ---- hdl/dcs_regs.svh ----
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
// ==========================================================
// register byte addresses on the serial control port
`define DCS_A_CFG 5'h00
`define DCS_A_INV 5'h01
`define DCS_A_SCL0 5'h02
`define DCS_A_FTW0 5'h08
`define DCS_A_STAT 5'h18
`define DCS_A_LAST 5'h19
`define DCS_NREG 26
// ==========================================================
// field positions and reset values
`define DCS_CFG_ISINC 0
`define DCS_STAT_SAT 0
`define DCS_SCALE_RST 8'hb5
`define DCS_SCALE_UNITY 8'h80
`define DCS_SCALE_SHIFT 7
// ==========================================================
// instruction byte layout
`define DCS_INS_RD 7
`define DCS_INS_NHI 6
`define DCS_INS_NLO 5
`define DCS_INS_AHI 4
// ==========================================================
// inverse sinc taps, scaled by 2**6: dc gain 43/64, about -3.45 db
`define DCS_FIR_EDGE 8'sh05
`define DCS_FIR_MID 8'sh35
`define DCS_FIR_SHIFT 6
// ==========================================================
// carrier generator constants
`define DCS_QTR_TURN 32'h4000_0000
`define DCS_PAR_SHIFT 8
`endif

// ---- hdl/dcs_pkg.sv ----
package dcs_pkg;
  // serial port sequencer states, one-hot
  typedef enum logic [1:0] {
    DCS_ST_INSTR = 2'b01,
    DCS_ST_DATA = 2'b10
  } dcs_state_t;
  // profile select
  typedef logic [1:0] dcs_prof_t;
endpackage

// ---- hdl/dcs_car_if.sv ----
// ==========================================================
// carrier reference samples from the generator to the modulator
interface dcs_car_if #(parameter int CW = 13);
  logic signed [CW-1:0] sin_s; // sine reference
  logic signed [CW-1:0] cos_s; // cosine reference
  modport src (output sin_s, output cos_s);
  modport snk (input sin_s, input cos_s);
endinterface

// ---- hdl/dcs_nco.sv ----
`include "dcs_regs.svh"
// ==========================================================
// phase accumulator with parabolic sine/cosine shaping
module dcs_nco #(
  parameter int PW = 32,
  parameter int CW = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // tuning
  input wire logic [PW-1:0] ftw,
  // carrier out
  dcs_car_if.src car
);
  import dcs_pkg::*;

  localparam int FW = 11; // phase bits inside a half turn
  logic [PW-1:0] phase_r; // accumulated phase
  logic [PW-1:0] phase_q; // phase shifted a quarter turn
  logic signed [CW-1:0] sin_nxt;
  logic signed [CW-1:0] cos_nxt;

  // parabola 4x(1-x) per half turn; cheaper than a table, ~5.6% peak error
  function automatic logic signed [CW-1:0] shape(input logic [PW-1:0] p);
    logic [FW-1:0] f;
    logic [2*FW:0] y;
    logic [CW-2:0] mag;
    f = p[PW-2 -: FW];
    y = (2*FW+1)'(f) * (2*FW+1)'((1 << FW) - int'(f));
    mag = (y[2*FW:`DCS_PAR_SHIFT] > (2*FW+1-`DCS_PAR_SHIFT)'((1 << (CW-1)) - 1)) ?
          {(CW-1){1'b1}} : y[`DCS_PAR_SHIFT +: CW-1];
    shape = p[PW-1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  assign phase_q = phase_r + `DCS_QTR_TURN;
  assign sin_nxt = shape(phase_r);
  assign cos_nxt = shape(phase_q);

  // ==========================================================
  // accumulate tuning word every sample clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + ftw;
    end
  end

  // sine and cosine both produced on every clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      car.sin_s <= '0;
      car.cos_s <= '0;
    end else begin
      car.sin_s <= sin_nxt;
      car.cos_s <= cos_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_phase_step: assert property (
    phase_r == $past(phase_r) + $past(ftw)) else $error("phase did not advance by ftw");
  chk_carrier_quad: assert property (
    !$past(rst) && $past(phase_r) == '0 |-> car.sin_s == '0 && car.cos_s == CW'((1 << (CW-1)) - 1))
    else $error("carrier pair not in quadrature at zero phase");
endmodule

// ---- hdl/dcs_top.sv ----
`include "dcs_regs.svh"
// Summary of operation
// - carrier frequency = tuning word * clock / 2^32
// - sine and cosine produced every clock
// - profile zero tuning word at bytes 08h-0Bh
// - optional inverse sinc fir before converter
// - inverse sinc dc gain about -3.5 db
// - bypassed filter passes samples, taps frozen
// - 8-bit scale, lsb weighs 2^-7
// - scale resets to b5h, about root two
// - scale 80h bypasses the multiplier
// - 14-bit samples to converter every clock
// - spectral invert selects sign of q term
module dcs_top #(
  parameter int DW = 14,
  parameter int CW = 13,
  parameter int PW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial control port pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio,
  input wire logic syncio,
  output logic sdo,
  output logic sdo_oe_n,
  // profile select pins
  input wire dcs_pkg::dcs_prof_t prof_sel,
  // baseband samples from the interpolators, same clock
  input wire logic signed [DW-1:0] i_data,
  input wire logic signed [DW-1:0] q_data,
  // converter samples
  output logic signed [DW-1:0] dac_data
);
  import dcs_pkg::*;

  localparam int MW = DW + 2; // modulator width with headroom
  localparam int SMAX = (1 << (DW-1)) - 1;

  // ==========================================================
  // pin synchronisers, two flops before any use
  logic [1:0] sclk_s_r, cs_s_r, sdio_s_r, sync_s_r;
  logic [1:0] prof_s1_r, prof_s2_r;
  logic sclk_d_r; // third stage for edge detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      sdio_s_r <= 2'h0;
      sync_s_r <= 2'h0;
      prof_s1_r <= 2'h0;
      prof_s2_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk};
      cs_s_r <= {cs_s_r[0], cs_n};
      sdio_s_r <= {sdio_s_r[0], sdio};
      sync_s_r <= {sync_s_r[0], syncio};
      prof_s1_r <= prof_sel;
      prof_s2_r <= prof_s1_r;
      sclk_d_r <= sclk_s_r[1];
    end
  end

  wire sel_w = ~cs_s_r[1]; // chip selected
  wire rise_w = sel_w & sclk_s_r[1] & ~sclk_d_r;
  wire fall_w = sel_w & ~sclk_s_r[1] & sclk_d_r;

  // ==========================================================
  // serial sequencer: instruction byte, then 1 to 4 data bytes
  dcs_state_t state_r;
  logic [2:0] bit_r; // bits of current byte taken
  logic [6:0] sh_r; // bits collected so far
  logic rd_r; // current cycle is a read
  logic [1:0] left_r; // data bytes still to go after this one
  logic [4:0] addr_r; // byte address
  logic commit_r; // one-cycle pulse: cycle finished
  logic sdo_r, sdo_oe_n_r;
  logic [7:0] stg_r [0:`DCS_NREG-1]; // bytes as written
  logic [7:0] act_r [0:`DCS_NREG-1]; // bytes in effect
  logic sat_r; // sticky saturation seen

  wire byte_done_w = rise_w & (bit_r == 3'h7);
  wire [7:0] byte_w = {sh_r, sdio_s_r[1]};
  wire wr_byte_w = byte_done_w & (state_r == DCS_ST_DATA) & ~rd_r;
  wire last_w = byte_done_w & (state_r == DCS_ST_DATA) & (left_r == 2'h0);
  // msb-first addressing walks downward and rolls 00h -> 19h
  wire [4:0] addr_dn_w = (addr_r == 5'h00) ? `DCS_A_LAST : addr_r - 5'h01;
  wire [4:0] next_a_w = (state_r == DCS_ST_INSTR) ? byte_w[`DCS_INS_AHI:0] : addr_dn_w;
  wire [7:0] stat_w = {7'h00, sat_r};
  wire [7:0] rd_byte_w = (addr_r == `DCS_A_STAT) ? stat_w :
                         (addr_r > `DCS_A_LAST) ? 8'h00 : stg_r[addr_r];

  // bit and state bookkeeping; syncio aborts, cs high only suspends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= DCS_ST_INSTR;
      bit_r <= 3'h0;
      sh_r <= 7'h00;
      rd_r <= 1'b0;
      left_r <= 2'h0;
      addr_r <= 5'h00;
    end else if (sync_s_r[1]) begin
      state_r <= DCS_ST_INSTR;
      bit_r <= 3'h0;
    end else if (rise_w) begin
      bit_r <= bit_r + 3'h1;
      sh_r <= byte_w[6:0];
      if (bit_r == 3'h7) begin
        unique case (state_r)
          DCS_ST_INSTR: begin
            rd_r <= byte_w[`DCS_INS_RD];
            left_r <= byte_w[`DCS_INS_NHI:`DCS_INS_NLO];
            addr_r <= next_a_w;
            state_r <= DCS_ST_DATA;
          end
          DCS_ST_DATA: begin
            left_r <= left_r - 2'h1;
            addr_r <= next_a_w;
            if (left_r == 2'h0) begin
              state_r <= DCS_ST_INSTR;
            end
          end
        endcase
      end
    end
  end

  // read data out on falling sclk, pin released outside reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdo_r <= 1'b0;
      sdo_oe_n_r <= 1'b1;
      commit_r <= 1'b0;
    end else begin
      commit_r <= last_w & ~sync_s_r[1];
      sdo_oe_n_r <= ~(sel_w & rd_r & (state_r == DCS_ST_DATA));
      if (fall_w) begin
        sdo_r <= rd_byte_w[3'h7 - bit_r];
      end
    end
  end

  // staging bytes; active copy taken once the whole cycle is in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < `DCS_NREG; k++) begin
        stg_r[k] <= (k >= `DCS_A_SCL0 && k < `DCS_A_SCL0 + 4) ? `DCS_SCALE_RST : 8'h00;
        act_r[k] <= (k >= `DCS_A_SCL0 && k < `DCS_A_SCL0 + 4) ? `DCS_SCALE_RST : 8'h00;
      end
    end else begin
      if (sync_s_r[1] && !commit_r) begin
        // an aborted cycle must not leave bytes that a later commit would apply
        stg_r <= act_r;
      end else if (wr_byte_w && addr_r <= `DCS_A_LAST) begin
        stg_r[addr_r] <= byte_w;
      end
      if (commit_r) begin
        act_r <= stg_r;
      end
    end
  end

  // ==========================================================
  // per-profile fields, and the filter enable shared by all profiles
  logic [PW-1:0] ftw_w [0:3];
  for (genvar p = 0; p < 4; p++) begin : g_ftw
    // highest address holds the most significant byte
    assign ftw_w[p] = {act_r[`DCS_A_FTW0 + 4*p + 3], act_r[`DCS_A_FTW0 + 4*p + 2],
                       act_r[`DCS_A_FTW0 + 4*p + 1], act_r[`DCS_A_FTW0 + 4*p]};
  end
  wire [PW-1:0] ftw_sel_w = ftw_w[prof_s2_r];
  wire [7:0] scale_w = act_r[`DCS_A_SCL0 + 5'(prof_s2_r)];
  wire inv_w = act_r[`DCS_A_INV][prof_s2_r];
  wire isinc_w = act_r[`DCS_A_CFG][`DCS_CFG_ISINC];

  // ==========================================================
  // carrier generator
  dcs_car_if #(.CW(CW)) car_if ();
  dcs_nco #(.PW(PW), .CW(CW)) u_nco (
    .clk(clk),
    .rst(rst),
    .ftw(ftw_sel_w),
    .car(car_if.src)
  );

  // ==========================================================
  // modulator: i*cos +/- q*sin, scaled back by the carrier amplitude
  wire signed [DW+CW-1:0] pi_w = i_data * car_if.cos_s;
  wire signed [DW+CW-1:0] pq_w = q_data * car_if.sin_s;
  wire signed [DW+CW:0] sum_w = inv_w ? pi_w + pq_w : pi_w - pq_w;
  wire signed [MW-1:0] mod_nxt = sum_w[CW-1 +: MW];
  logic signed [MW-1:0] mod_r, tap1_r, tap2_r, fir_r;

  // inverse sinc taps; held still when bypassed, which stands in for a stopped clock
  wire signed [MW+8:0] acc_w = `DCS_FIR_MID * tap1_r - `DCS_FIR_EDGE * (mod_r + tap2_r);
  wire signed [MW-1:0] fir_nxt = acc_w[`DCS_FIR_SHIFT +: MW];
  wire signed [MW-1:0] fsel_w = isinc_w ? fir_r : mod_r;

  // output scale; unity skips the multiplier altogether
  wire signed [MW+8:0] prod_w = fsel_w * $signed({1'b0, scale_w});
  wire signed [MW+1:0] scl_w = (scale_w == `DCS_SCALE_UNITY) ?
                               (MW+2)'(fsel_w) : prod_w[`DCS_SCALE_SHIFT +: MW+2];
  wire hi_w = scl_w > (MW+2)'(SMAX);
  wire lo_w = scl_w < -(MW+2)'(SMAX) - (MW+2)'(1);
  wire signed [DW-1:0] sat_w = hi_w ? DW'(SMAX) : lo_w ? DW'(-SMAX - 1) : scl_w[DW-1:0];
  wire clr_sat_w = wr_byte_w & (addr_r == `DCS_A_STAT) & ~byte_w[`DCS_STAT_SAT];

  // datapath pipeline, one sample per clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_r <= '0;
      tap1_r <= '0;
      tap2_r <= '0;
      fir_r <= '0;
      dac_data <= '0;
      sat_r <= 1'b0;
    end else begin
      mod_r <= mod_nxt;
      if (isinc_w) begin
        tap1_r <= mod_r;
        tap2_r <= tap1_r;
        fir_r <= fir_nxt;
      end
      dac_data <= sat_w;
      // a new overflow beats a clear in the same cycle
      sat_r <= (hi_w | lo_w) | (sat_r & ~clr_sat_w);
    end
  end

  assign sdo = sdo_r;
  assign sdo_oe_n = sdo_oe_n_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_scale_reset: assert property (
    $past(rst) |-> act_r[`DCS_A_SCL0] == `DCS_SCALE_RST) else $error("scale not b5h after reset");
  chk_word_whole: assert property (
    !$past(commit_r) |-> ftw_w[0] == $past(ftw_w[0])) else $error("tuning word changed outside commit");
  chk_word_commit: assert property (
    commit_r |=> ftw_w[0] == {$past(stg_r[11]), $past(stg_r[10]), $past(stg_r[9]), $past(stg_r[8])})
    else $error("tuning word not taken from 08h-0bh");
  chk_mod_sign: assert property (
    mod_r == $past(inv_w ? pi_w + pq_w : pi_w - pq_w) >>> (CW-1)) else $error("modulator sign wrong");
  chk_fir_frozen: assert property (
    !isinc_w |=> $stable(tap1_r) && $stable(fir_r)) else $error("bypassed filter still moving");
  chk_fir_path: assert property (
    isinc_w && $past(isinc_w) |-> fir_r == $past(fir_nxt)) else $error("filter output wrong");
  chk_unity_pass: assert property (
    scale_w == `DCS_SCALE_UNITY && !hi_w && !lo_w |=> dac_data == $past(fsel_w[DW-1:0]))
    else $error("unity scale altered sample");
  chk_sat_top: assert property (
    hi_w |=> dac_data == DW'(SMAX)) else $error("positive overflow not clipped");
  chk_sat_sticky: assert property (
    hi_w || lo_w |=> sat_r) else $error("saturation flag lost");
  cov_isinc_on: cover property (isinc_w && fir_r != '0);
  cov_commit: cover property (commit_r);
  cov_sat: cover property (hi_w || lo_w);
  cov_sdo_read: cover property (!sdo_oe_n_r && fall_w);
endmodule

// ---- testbench/dcs_dac_model.sv ----
// ==========================================================
// behavioural 14-bit converter at the far side of the block
module dcs_dac_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // converter word
  input wire logic signed [13:0] dac_data,
  // latched word and the one before it
  output logic signed [13:0] smp_r,
  output logic signed [13:0] prev_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // one word is latched on every sample clock, no skipping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smp_r <= '0;
      prev_r <= '0;
    end else begin
      smp_r <= dac_data;
      prev_r <= smp_r;
    end
  end
endmodule

// ---- testbench/dds_carrier_output_scaling_tb.sv ----
// ==========================================================
// self-checking bench for the carrier back end
module dds_carrier_output_scaling_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcs_pkg::*;
  logic clk = 1'b0; // sample clock
  logic rst = 1'b1; // async reset
  logic sclk = 1'b0; // serial pins
  logic cs_n = 1'b1;
  logic sdio = 1'b0;
  logic syncio = 1'b0;
  logic sdo;
  logic sdo_oe_n;
  dcs_prof_t prof_sel = 2'h0; // profile 0 only, the others share the logic
  logic signed [13:0] i_data = '0; // baseband
  logic signed [13:0] q_data = '0;
  logic signed [13:0] dac_data;
  logic signed [13:0] smp; // converter view
  logic signed [13:0] prev;
  int err_total = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  dcs_top #(.DW(14), .CW(13), .PW(32)) dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio(sdio),
    .syncio(syncio), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .prof_sel(prof_sel), .i_data(i_data), .q_data(q_data),
    .dac_data(dac_data));
  dcs_dac_model dac (.clk(clk), .rst(rst), .dac_data(dac_data), .smp_r(smp), .prev_r(prev));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one serial cycle, msb first; six clocks per sclk phase keep the synchroniser happy
  // cut aborts with syncio before that bit, to show nothing half-written lands
  task automatic spi(input logic [7:0] ins, input int nb, input logic [31:0] wd, input int cut,
                     output logic [31:0] rd);
    logic [39:0] sh;
    sh = {ins, wd << (8 * (4 - nb))};
    rd = '0;
    cs_n = 1'b0;
    for (int b = 0; b < 8 + 8 * nb; b++) begin
      if (b == cut) begin
        syncio = 1'b1;
        clks(6);
        syncio = 1'b0;
        break;
      end
      sdio = sh[39];
      sh = sh << 1;
      clks(6);
      if (b >= 8) begin
        rd = {rd[30:0], sdo};
        chk(32'(sdo_oe_n), 32'(!ins[7]), "sdo enable in data phase");
      end
      sclk = 1'b1;
      clks(6);
      sclk = 1'b0;
    end
    clks(6);
    cs_n = 1'b1;
    clks(6);
  endtask
  task automatic wr(input logic [4:0] a, input int nb, input logic [31:0] d);
    logic [31:0] r;
    spi({1'b0, 2'(nb - 1), a}, nb, d, 99, r);
  endtask
  task automatic rdr(input logic [4:0] a, input int nb, output logic [31:0] r);
    spi({1'b1, 2'(nb - 1), a}, nb, 32'h0, 99, r);
  endtask
  // hold a baseband pair long enough to flush the pipeline
  task automatic iq(input int i, input int q);
    i_data = 14'(i);
    q_data = 14'(q);
    clks(10);
  endtask
  // ==========================================================
  // scenarios; phase stays at zero until a tuning word is written
  task automatic t_reset();
    logic [31:0] r;
    chk(32'(sdo_oe_n), 32'h1, "sdo released while idle");
    rdr(5'h02, 1, r);
    chk(r, 32'hb5, "scale after reset");
    rdr(5'h0b, 4, r);
    chk(r, 32'h0, "tuning word after reset");
    iq(129, 0);
    chk(32'(smp), 32'd181, "default gain");
    $display("test reset done");
  endtask
  task automatic t_scale();
    logic [7:0] sv [4] = '{8'h80, 8'h00, 8'h01, 8'hff};
    logic [31:0] r;
    // a modulator word of 128 makes the expected output equal the scale code
    foreach (sv[k]) begin
      wr(5'h02, 1, 32'(sv[k]));
      iq(129, 0);
      chk(32'(smp), 32'(sv[k]), "scaled sample");
    end
    iq(8191, 0);
    chk(32'(smp), 32'(8191), "positive clip");
    iq(-8192, 0);
    chk(32'(smp), 32'(-8192), "negative clip");
    rdr(5'h18, 1, r);
    chk(r, 32'h1, "clip flag set");
    wr(5'h02, 1, 32'h80);
    wr(5'h18, 1, 32'h0);
    rdr(5'h18, 1, r);
    chk(r, 32'h0, "clip flag cleared");
    iq(8191, 0);
    chk(32'(smp), 32'(8189), "unity passes large word");
    iq(-8192, 0);
    chk(32'(smp), 32'(-8190), "unity passes negative word");
    $display("test scale done");
  endtask
  task automatic t_fir();
    // dc through taps summing to 43/64, roughly 3.5 db down
    wr(5'h00, 1, 32'h1);
    iq(4096, 0);
    chk(32'(smp >= 2748 && smp <= 2754), 32'h1, "filtered dc level");
    wr(5'h00, 1, 32'h0);
    iq(4096, 0);
    chk(32'(smp), 32'(4095), "bypassed dc level");
    $display("test filter done");
  endtask
  task automatic t_freq();
    logic signed [13:0] a [8];
    logic [31:0] r;
    wr(5'h0b, 4, 32'h4000_0000); // quarter turn, below 2**31
    rdr(5'h0b, 1, r);
    chk(r, 32'h40, "msb at top address");
    spi(8'h6b, 4, 32'h1234_5678, 24, r);
    rdr(5'h0b, 4, r);
    chk(r, 32'h4000_0000, "aborted write dropped");
    iq(4096, 0);
    for (int k = 0; k < 8; k++) begin
      a[k] = smp;
      clks(1);
    end
    for (int k = 0; k < 4; k++) begin
      chk(32'(a[k + 4]), 32'(a[k]), "four-sample period");
      chk(32'(a[k] !== a[k + 1]), 32'h1, "fresh sample each clock");
    end
    $display("test frequency done");
  endtask
  task automatic t_invert();
    int n;
    wr(5'h0b, 4, 32'h0100_0000); // slow carrier, 256 clocks a turn
    for (int inv = 1; inv >= 0; inv--) begin
      wr(5'h01, 1, 32'(inv));
      iq(4096, 0);
      // find the cosine falling while positive, so the sine is positive there
      n = 0;
      while (!(smp > 2000 && smp < prev) && n < 600) begin
        clks(1);
        n++;
      end
      iq(0, 4096);
      chk(32'(inv ? smp > 0 : smp < 0), 32'h1, "sign of quadrature term");
    end
    $display("test invert done");
  endtask
  // ==========================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    clks(4);
    t_reset();
    t_scale();
    t_fir();
    t_freq();
    t_invert();
    results();
  end
  // about 6000 clocks are needed; a hang is cut well past that
  initial begin
    #(60000 * 40);
    err_total++;
    results();
  end
endmodule
